// ### verilog/dfc_defines.svh
// Purpose: Constants for the debug freeze configuration register
// Assumes: 32-bit register, word access only
// Notes: Bit positions and reset value
`ifndef DFC_DEFINES_SVH
`define DFC_DEFINES_SVH
`define DFC_REG_ADDR        32'hE0042004
`define DFC_RESET_VALUE     32'h00000000
`define DFC_WRITE_MASK      32'h001FFFE7
`define DFC_BIT_SLEEP       0
`define DFC_BIT_STOP        1
`define DFC_BIT_STANDBY     2
`define DFC_BIT_TRACE_EN    5
`define DFC_BIT_MODE_LO     6
`define DFC_BIT_MODE_HI     7
`define DFC_BIT_IWDG        8
`define DFC_BIT_WWDG        9
`define DFC_BIT_TIM_LO_LSB  10
`define DFC_BIT_CAN         14
`define DFC_BIT_TW1         15
`define DFC_BIT_TW2         16
`define DFC_BIT_TIM_HI_LSB  17
`define DFC_TRACE_CLK_DELAY 2'h2
`endif

// ### verilog/dfc_pkg.sv
// Purpose: Types for the debug freeze configuration block
// Assumes: Constants come from dfc_defines.svh
// Notes: State is one packed struct
package dfc_pkg;
	typedef enum logic [1:0] {
		DFC_TRACE_ASYNC = 2'h0,
		DFC_TRACE_SYNC1 = 2'h1,
		DFC_TRACE_SYNC2 = 2'h2,
		DFC_TRACE_SYNC4 = 2'h3
	} dfc_trace_mode_t;
	typedef enum logic [2:0] {
		DFC_TCK_LOW  = 3'h1,
		DFC_TCK_WAIT = 3'h2,
		DFC_TCK_RUN  = 3'h4
	} dfc_tck_state_t;
	typedef struct packed {
		logic [31:0]    cfg;
		dfc_tck_state_t tck_state;
		logic [1:0]     tck_count;
	} dfc_state_t;
endpackage

// ### verilog/dfc_debug_freeze_config.sv
// Purpose: Debug freeze configuration register and its control decode
// Assumes: Word bus access; rst is the power-on reset and the only reset of the register
// Notes: System reset does not touch the register
// Function
// - Fixed address, full 32-bit word access only
// - Cleared only by power-on reset
// - Debugger writes accepted during system reset
// - Application software writes also accepted
// - Upper timers stop and outputs break when halted
// - Lower timers stop clock when halted
// - SMBus timeouts freeze when halted
// - CAN receive registers freeze when halted
// - Window watchdog clock stops when halted
// - Independent watchdog clock stops when halted
// - Trace enable off assigns no trace pins
// - Trace mode selects async or sync width
// - Standby debug keeps power, RC clock, reset
// - Stop without debug gates core free and bus clocks
// - Stop debug feeds clocks from RC oscillator
// - Sleep without debug gates bus clock only
// - Sleep debug keeps bus clock running
// - Trace clock enabled two cycles after enable
`timescale 1ns/1ps
`include "dfc_defines.svh"
module dfc_debug_freeze_config
	import dfc_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        dbg_sel,
	input  wire logic        dbg_write,
	input  wire logic [31:0] dbg_addr,
	input  wire logic [31:0] dbg_wdata,
	input  wire logic [3:0]  dbg_byte_en,
	output logic      [31:0] dbg_rdata,
	output logic             dbg_error,
	input  wire logic        sw_sel,
	input  wire logic        sw_write,
	input  wire logic [31:0] sw_addr,
	input  wire logic [31:0] sw_wdata,
	input  wire logic [3:0]  sw_byte_en,
	output logic      [31:0] sw_rdata,
	output logic             sw_error,
	input  wire logic        core_halted,
	input  wire logic        sleep_mode,
	input  wire logic        stop_mode,
	input  wire logic        standby_mode,
	output logic      [3:0]  timer_hi_clk_stop,
	output logic      [3:0]  timer_hi_break,
	output logic      [3:0]  timer_lo_clk_stop,
	output logic             twowire1_timeout_hold,
	output logic             twowire2_timeout_hold,
	output logic             can_rx_hold,
	output logic             window_watchdog_hold,
	output logic             indep_watchdog_hold,
	output logic             trace_async_pin_en,
	output logic             trace_clk_pin_en,
	output logic      [3:0]  trace_data_pin_en,
	output logic             trace_port_clock_en,
	output logic             core_free_clock_en,
	output logic             bus_clock_en,
	output logic             clk_from_internal_rc_osc,
	output logic             digital_power_on,
	output logic             standby_sys_reset,
	output logic             clock_ctrl_reset
);
	dfc_state_t      st;
	dfc_state_t      next_st;
	logic            dbg_hit;
	logic            sw_hit;
	logic [31:0]     cfg_rd;
	dfc_trace_mode_t mode;

	// Only full-word accesses at the one address hit
	assign dbg_hit = dbg_sel && dbg_addr == `DFC_REG_ADDR && dbg_byte_en == 4'hF;
	assign sw_hit  = sw_sel && sw_addr == `DFC_REG_ADDR && sw_byte_en == 4'hF;
	assign cfg_rd  = st.cfg & `DFC_WRITE_MASK;
	assign mode    = dfc_trace_mode_t'(st.cfg[`DFC_BIT_MODE_HI:`DFC_BIT_MODE_LO]);

	always_comb begin
		next_st = st;
		// Debugger wins a same-cycle collision; no system reset term gates writes
		if (dbg_hit && dbg_write) begin
			next_st.cfg = dbg_wdata & `DFC_WRITE_MASK;
		end else if (sw_hit && sw_write) begin
			next_st.cfg = sw_wdata & `DFC_WRITE_MASK;
		end
		case (st.tck_state)
			DFC_TCK_LOW: begin
				next_st.tck_count = 2'h0;
				if (st.cfg[`DFC_BIT_TRACE_EN]) begin
					next_st.tck_state = DFC_TCK_WAIT;
					next_st.tck_count = 2'h1;
				end
			end
			DFC_TCK_WAIT: begin
				if (!st.cfg[`DFC_BIT_TRACE_EN]) begin
					next_st.tck_state = DFC_TCK_LOW;
				end else if (st.tck_count == `DFC_TRACE_CLK_DELAY - 2'h1) begin
					next_st.tck_state = DFC_TCK_RUN;
				end else begin
					next_st.tck_count = st.tck_count + 2'h1;
				end
			end
			DFC_TCK_RUN: begin
				if (!st.cfg[`DFC_BIT_TRACE_EN]) begin
					next_st.tck_state = DFC_TCK_LOW;
				end
			end
			default: begin
				next_st.tck_state = DFC_TCK_LOW;
			end
		endcase
	end

	// Power-on reset only; system reset is not a port here
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st.cfg       <= `DFC_RESET_VALUE;
			st.tck_state <= DFC_TCK_LOW;
			st.tck_count <= 2'h0;
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		dbg_rdata = dbg_hit ? cfg_rd : 32'h00000000;
		sw_rdata  = sw_hit ? cfg_rd : 32'h00000000;
		dbg_error = dbg_sel && !dbg_hit;
		sw_error  = sw_sel && !sw_hit;
	end

	// Per-timer freeze decode
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_tim
			assign timer_hi_clk_stop[i] = core_halted && st.cfg[`DFC_BIT_TIM_HI_LSB + i];
			assign timer_hi_break[i]    = core_halted && st.cfg[`DFC_BIT_TIM_HI_LSB + i];
			assign timer_lo_clk_stop[i] = core_halted && st.cfg[`DFC_BIT_TIM_LO_LSB + i];
		end
	endgenerate

	assign twowire1_timeout_hold = core_halted && st.cfg[`DFC_BIT_TW1];
	assign twowire2_timeout_hold = core_halted && st.cfg[`DFC_BIT_TW2];
	assign can_rx_hold           = core_halted && st.cfg[`DFC_BIT_CAN];
	assign window_watchdog_hold  = core_halted && st.cfg[`DFC_BIT_WWDG];
	assign indep_watchdog_hold   = core_halted && st.cfg[`DFC_BIT_IWDG];

	// Trace pin assignment
	always_comb begin
		trace_async_pin_en = 1'b0;
		trace_clk_pin_en   = 1'b0;
		trace_data_pin_en  = 4'h0;
		if (st.cfg[`DFC_BIT_TRACE_EN]) begin
			case (mode)
				DFC_TRACE_ASYNC: begin
					trace_async_pin_en = 1'b1;
				end
				DFC_TRACE_SYNC1: begin
					trace_clk_pin_en  = 1'b1;
					trace_data_pin_en = 4'h1;
				end
				DFC_TRACE_SYNC2: begin
					trace_clk_pin_en  = 1'b1;
					trace_data_pin_en = 4'h3;
				end
				DFC_TRACE_SYNC4: begin
					trace_clk_pin_en  = 1'b1;
					trace_data_pin_en = 4'hF;
				end
				default: begin
					trace_async_pin_en = 1'b0;
				end
			endcase
		end
	end

	assign trace_port_clock_en = st.tck_state == DFC_TCK_RUN;

	// Low-power clock and power control
	always_comb begin
		core_free_clock_en       = 1'b1;
		bus_clock_en             = 1'b1;
		clk_from_internal_rc_osc = 1'b0;
		digital_power_on         = 1'b1;
		standby_sys_reset        = 1'b0;
		clock_ctrl_reset         = 1'b0;
		if (standby_mode) begin
			if (st.cfg[`DFC_BIT_STANDBY]) begin
				clk_from_internal_rc_osc = 1'b1;
				standby_sys_reset        = 1'b1;
			end else begin
				digital_power_on   = 1'b0;
				core_free_clock_en = 1'b0;
				bus_clock_en       = 1'b0;
			end
		end else if (stop_mode) begin
			clock_ctrl_reset = 1'b1;
			if (st.cfg[`DFC_BIT_STOP]) begin
				clk_from_internal_rc_osc = 1'b1;
			end else begin
				core_free_clock_en = 1'b0;
				bus_clock_en       = 1'b0;
			end
		end else if (sleep_mode) begin
			bus_clock_en = st.cfg[`DFC_BIT_SLEEP];
		end
	end
endmodule

// ### bench/dfc_checker.sv
// Purpose: Port assertions for the configuration block
// Assumes: Bound to every instance
// Notes: One clock domain
`timescale 1ns/1ps
`include "dfc_defines.svh"
module dfc_checker (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        dbg_sel,
	input wire logic        dbg_write,
	input wire logic [31:0] dbg_addr,
	input wire logic [31:0] dbg_wdata,
	input wire logic [3:0]  dbg_byte_en,
	input wire logic        dbg_error,
	input wire logic        core_halted,
	input wire logic        stop_mode,
	input wire logic        standby_mode,
	input wire logic [3:0]  timer_hi_clk_stop,
	input wire logic [3:0]  timer_hi_break,
	input wire logic        indep_watchdog_hold,
	input wire logic        trace_async_pin_en,
	input wire logic        trace_clk_pin_en,
	input wire logic [3:0]  trace_data_pin_en,
	input wire logic        trace_port_clock_en,
	input wire logic        core_free_clock_en,
	input wire logic        bus_clock_en,
	input wire logic        clk_from_internal_rc_osc,
	input wire logic        standby_sys_reset
);
	logic ok;
	logic pins;
	assign ok = dbg_addr == `DFC_REG_ADDR && dbg_byte_en == 4'hF;
	assign pins = trace_async_pin_en | trace_clk_pin_en;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	bad_access_a: assert property (dbg_sel && !ok |-> dbg_error)
		else $error("bad access");
	dbg_write_a: assert property (dbg_sel && dbg_write && ok
		|=> indep_watchdog_hold == (core_halted && $past(dbg_wdata[8]))) else $error("write lost");
	timer_break_a: assert property (timer_hi_break == timer_hi_clk_stop) else $error("break");
	run_free_a: assert property (!core_halted |-> timer_hi_clk_stop == 4'h0 && !indep_watchdog_hold)
		else $error("freeze while running");
	async_pin_a: assert property (trace_async_pin_en |-> !trace_clk_pin_en && trace_data_pin_en == 4'h0)
		else $error("async pins");
	sync_width_a: assert property (trace_clk_pin_en == (trace_data_pin_en != 4'h0) &&
		trace_data_pin_en inside {4'h0, 4'h1, 4'h3, 4'hF}) else $error("sync width");
	trace_clock_a: assert property ($rose(trace_port_clock_en)
		|-> pins && $past(pins, 2) && !$past(pins, 3)) else $error("trace clock");
	standby_keep_a: assert property (standby_mode && bus_clock_en
		|-> standby_sys_reset && clk_from_internal_rc_osc && core_free_clock_en) else $error("standby");
	stop_clocks_a: assert property (stop_mode && !standby_mode |-> bus_clock_en == core_free_clock_en
		&& (!bus_clock_en || clk_from_internal_rc_osc)) else $error("stop clocks");
endmodule
bind dfc_debug_freeze_config dfc_checker chk (.*);

// ### bench/dfc_host.sv
// Purpose: Word bus master model
// Assumes: One access per call
// Notes: Released bus drops sel and shows inverted address, data and byte enables; wr keeps its value
`timescale 1ns/1ps
module dfc_host (
	input  wire logic        core_clk,
	output logic             sel,
	output logic             wr,
	output logic      [31:0] addr,
	output logic      [31:0] wdata,
	output logic      [3:0]  be,
	input  wire logic [31:0] rdata,
	input  wire logic        err
);
	initial {sel, wr, addr, wdata, be} = 70'h0;
	task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] b, output logic [31:0] rd, output logic e);
		@(negedge core_clk);
		{sel, wr, addr, wdata} = {1'b1, w, a, d};
		be = b;
		@(posedge core_clk);
		rd = rdata;
		e = err;
		@(negedge core_clk);
		{sel, addr, wdata, be} = {1'b0, ~a, ~d, ~b};
	endtask
endmodule

// ### bench/debug_freeze_config_tb.sv
// Purpose: Self-checking bench for the configuration block
// Assumes: Debugger and software hosts
// Notes: Xorshift data, seed 3631
`timescale 1ns/1ps
`include "dfc_defines.svh"
module debug_freeze_config_tb;
	logic        core_clk, rst, core_halted, sleep_mode, stop_mode, standby_mode, e;
	logic        dbg_sel, dbg_write, dbg_error, sw_sel, sw_write, sw_error;
	logic [31:0] dbg_addr, dbg_wdata, dbg_rdata, sw_addr, sw_wdata, sw_rdata, seed, d, r;
	logic [3:0]  dbg_byte_en, sw_byte_en, timer_hi_clk_stop, timer_hi_break;
	logic [3:0]  timer_lo_clk_stop, trace_data_pin_en;
	logic        twowire1_timeout_hold, twowire2_timeout_hold, can_rx_hold, bus_clock_en;
	logic        window_watchdog_hold, indep_watchdog_hold, trace_async_pin_en;
	logic        trace_clk_pin_en, trace_port_clock_en, core_free_clock_en, clock_ctrl_reset;
	logic        clk_from_internal_rc_osc, digital_power_on, standby_sys_reset;
	int          err_total, num_checks, i;
	dfc_debug_freeze_config uut (.*);
	dfc_host dh (.core_clk, .sel(dbg_sel), .wr(dbg_write), .addr(dbg_addr),
		.wdata(dbg_wdata), .be(dbg_byte_en), .rdata(dbg_rdata), .err(dbg_error));
	dfc_host sh (.core_clk, .sel(sw_sel), .wr(sw_write), .addr(sw_addr),
		.wdata(sw_wdata), .be(sw_byte_en), .rdata(sw_rdata), .err(sw_error));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [5:0] pin_exp(input logic [31:0] c);
		if (!c[5]) return 6'h00;
		case (c[7:6])
			2'h0: return 6'h20;
			2'h1: return 6'h11;
			2'h2: return 6'h13;
			default: return 6'h1F;
		endcase
	endfunction
	function automatic logic [2:0] lp_exp(input logic [31:0] c, input logic [1:0] m);
		case (m)
			2'h1: return c[0] ? 3'h7 : 3'h5;
			2'h2: return c[1] ? 3'h7 : 3'h1;
			2'h3: return c[2] ? 3'h7 : 3'h0;
			default: return 3'h7;
		endcase
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			err_total++;
			$display("ERROR %0t: got %h want %h", $time, g, x);
		end
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		seed = 32'h00000E2F;
		{rst, core_halted, sleep_mode, stop_mode, standby_mode} = 5'h10;
		repeat (3) @(negedge core_clk);
		rst = 1'b0;
		sh.acc(1'b0, `DFC_REG_ADDR, 32'h0, 4'hF, r, e);
		chk(r, 32'h0);
		for (i = 0; i < 40; i++) begin
			seed = xs(seed);
			d = ((i == 0) ? 32'hFFFFFFFF : seed) & `DFC_WRITE_MASK;
			if (i[0]) sh.acc(1'b1, `DFC_REG_ADDR, d, 4'hF, r, e);
			else dh.acc(1'b1, `DFC_REG_ADDR, d, 4'hF, r, e);
			core_halted = seed[31];
			{standby_mode, stop_mode, sleep_mode} = 3'((4'h1 << seed[30:29]) >> 1);
			#1;
			chk({timer_hi_break, timer_hi_clk_stop, timer_lo_clk_stop}, {d[20:17], d[20:17], d[13:10]} & {12{seed[31]}});
			chk({twowire2_timeout_hold, twowire1_timeout_hold, can_rx_hold, window_watchdog_hold, indep_watchdog_hold}, {d[16:14], d[9:8]} & {5{seed[31]}});
			chk({trace_async_pin_en, trace_clk_pin_en, trace_data_pin_en}, pin_exp(d));
			chk({core_free_clock_en, bus_clock_en, digital_power_on}, lp_exp(d, seed[30:29]));
			chk({clock_ctrl_reset, clk_from_internal_rc_osc, standby_sys_reset},
				{seed[30:29] == 2'h2, (seed[30:29] == 2'h2 && d[1]) || (seed[30:29] == 2'h3 && d[2]),
				seed[30:29] == 2'h3 && d[2]});
			if (i[0]) dh.acc(1'b0, `DFC_REG_ADDR, 32'h0, 4'hF, r, e);
			else sh.acc(1'b0, `DFC_REG_ADDR, 32'h0, 4'hF, r, e);
			chk(r, d & 32'h001FFFE7);
		end
		{standby_mode, stop_mode, sleep_mode} = 3'h0;
		dh.acc(1'b1, `DFC_REG_ADDR, 32'h0, 4'hF, r, e);
		dh.acc(1'b1, `DFC_REG_ADDR, 32'h20, 4'hF, r, e);
		for (i = 0; i < 3; i++) begin
			chk(trace_port_clock_en, i == 2);
			@(negedge core_clk);
		end
		dh.acc(1'b1, `DFC_REG_ADDR, 32'h1, 4'h3, r, e);
		chk(e, 1'b1);
		sh.acc(1'b1, `DFC_REG_ADDR + 32'h4, 32'h1, 4'hF, r, e);
		chk(e, 1'b1);
		fork
			dh.acc(1'b1, `DFC_REG_ADDR, 32'h100, 4'hF, r, e);
			sh.acc(1'b1, `DFC_REG_ADDR, 32'h200, 4'hF, d, e);
		join
		sh.acc(1'b0, `DFC_REG_ADDR, 32'h0, 4'hF, r, e);
		chk(r, 32'h100);
		rst = 1'b1;
		@(negedge core_clk);
		rst = 1'b0;
		dh.acc(1'b0, `DFC_REG_ADDR, 32'h0, 4'hF, r, e);
		chk(r, 32'h0);
		summarize;
	end
endmodule
